// *** rtl/srp_pkg.sv ***
// Shared constants and types for the serial register port slave.
// Assumes one system clock; the serial bus pins arrive asynchronously.
package srp_pkg;

  // Select byte field layout
  localparam int SEL_REG_MSB = 6;
  localparam int SEL_REG_LSB = 3;
  localparam int SEL_PORT_MSB = 1;
  localparam int SEL_PORT_LSB = 0;
  localparam logic [3:0] SEL_REG_RESET = 4'h0;
  localparam logic [1:0] SEL_PORT_RESET = 2'h0;

  // Register select codes
  localparam logic [3:0] REG_COMMON_READ = 4'h0;
  localparam logic [3:0] REG_COMMON_CTRL = 4'h1;
  localparam logic [3:0] REG_PORT_CTRL1 = 4'h2;
  localparam logic [3:0] REG_PORT_CTRL2 = 4'h3;
  localparam logic [3:0] REG_PORT_STAT1 = 4'h4;
  localparam logic [3:0] REG_PORT_STAT2 = 4'h5;
  localparam logic [3:0] REG_RES_LO = 4'h6;
  localparam logic [3:0] REG_RES_HI = 4'h7;
  localparam logic [3:0] REG_VOLT_LO = 4'h8;
  localparam logic [3:0] REG_VOLT_HI = 4'h9;
  localparam logic [3:0] REG_CURR_LO = 4'ha;
  localparam logic [3:0] REG_CURR_HI = 4'hb;
  localparam logic [3:0] REG_TEMP_LO = 4'hc;
  localparam logic [3:0] REG_TEMP_HI = 4'hd;
  localparam logic [3:0] REG_UNUSED = 4'he;
  localparam logic [3:0] REG_TEST = 4'hf;

  // Byte handling
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] UNUSED_READ = 8'h00;

  // Address strap synchroniser value after reset
  localparam logic [4:0] PINS_RESET = 5'h00;

  // Selection result travelling to the register space
  typedef struct packed {
    logic [3:0] reg_code;
    logic [1:0] port;
  } srp_sel_t;

  // Transaction phases, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_SEL = 6'h08,
    ST_RDATA = 6'h10,
    ST_MACK = 6'h20
  } srp_state_t;

endpackage

// *** rtl/srp_slave.sv ***
// Serial two-wire slave: address match, select byte, read data out.
// Assumes the bus pins are asynchronous and sampled at sys_clk.
`timescale 1ns/1ps

module srp_slave
  import srp_pkg::*;
(
  // Clock and control
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Serial bus pins, clock is input only
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_oen,
  // Address strap pins
  input wire logic [4:0] address_select_pins,
  // Register space contents for the selected port
  input wire logic [7:0] common_read_val,
  input wire logic [7:0] common_ctrl_val,
  input wire logic [7:0] port_ctrl1_val,
  input wire logic [7:0] port_ctrl2_val,
  input wire logic [7:0] port_stat1_val,
  input wire logic [7:0] port_stat2_val,
  input wire logic [15:0] res_val,
  input wire logic [15:0] volt_val,
  input wire logic [15:0] curr_val,
  input wire logic [15:0] temp_val,
  input wire logic [7:0] test_val,
  // Selection and read strobe
  output srp_sel_t sel,
  output logic read_active
);

  // Pin synchronisers, first stage read only by second
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [4:0] pins_meta_reg;
  logic [4:0] pins_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      pins_meta_reg <= PINS_RESET;
      pins_reg <= PINS_RESET;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      pins_meta_reg <= address_select_pins; // Straps are off-domain pins too
      pins_reg <= pins_meta_reg;
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // Bus events from the synchronised levels
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s && !scl_d_reg;
  wire scl_fall = !scl_s && scl_d_reg;
  wire start_ev = scl_s && scl_d_reg && !sda_s && sda_d_reg;
  wire stop_ev = scl_s && scl_d_reg && sda_s && !sda_d_reg;

  // Read data mux for the selected register
  function automatic logic [7:0] read_mux(input logic [3:0] code,
                                          input logic [7:0] cr, cc, p1, p2,
                                          input logic [7:0] s1, s2,
                                          input logic [15:0] r, v, c, t,
                                          input logic [7:0] tst);
    logic [7:0] d;
    d = UNUSED_READ;
    case (code)
      REG_COMMON_READ: d = cr;
      REG_COMMON_CTRL: d = cc;
      REG_PORT_CTRL1: d = p1;
      REG_PORT_CTRL2: d = p2;
      REG_PORT_STAT1: d = s1;
      REG_PORT_STAT2: d = s2;
      REG_RES_LO: d = r[7:0];
      REG_RES_HI: d = r[15:8];
      REG_VOLT_LO: d = v[7:0];
      REG_VOLT_HI: d = v[15:8];
      REG_CURR_LO: d = c[7:0];
      REG_CURR_HI: d = c[15:8];
      REG_TEMP_LO: d = t[7:0];
      REG_TEMP_HI: d = t[15:8];
      REG_TEST: d = tst;
      default: d = UNUSED_READ;
    endcase
    return d;
  endfunction

  srp_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic rw_reg;
  logic after_addr_reg;
  logic [7:0] tx_reg;

  // Decode of the received byte
  wire addr_match = (shift_reg[5:1] == pins_reg);
  wire [3:0] rx_code = shift_reg[SEL_REG_MSB:SEL_REG_LSB];
  wire [1:0] rx_port = shift_reg[SEL_PORT_MSB:SEL_PORT_LSB];
  wire byte_done = (bit_cnt_reg == BITS_PER_BYTE);
  wire [7:0] rd_byte = read_mux(sel.reg_code, common_read_val, common_ctrl_val,
                                port_ctrl1_val, port_ctrl2_val, port_stat1_val,
                                port_stat2_val, res_val, volt_val, curr_val,
                                temp_val, test_val);

  // Phase sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_ADDR: begin
        if (scl_fall && byte_done) begin
          state_next = addr_match ? ST_ACK : ST_IDLE;
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          if (after_addr_reg && rw_reg) begin
            state_next = ST_RDATA;
          end else if (after_addr_reg) begin
            state_next = ST_SEL;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_SEL: begin
        if (scl_fall && byte_done) begin
          state_next = ST_ACK;
        end
      end
      ST_RDATA: begin
        if (scl_fall && byte_done) begin
          state_next = ST_MACK;
        end
      end
      ST_MACK: begin
        if (scl_fall) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (start_ev) begin
      state_next = ST_ADDR;
    end else if (stop_ev) begin
      state_next = ST_IDLE;
    end
  end

  // State, bit counter and shifters
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= BIT_CNT_RESET;
      shift_reg <= BYTE_RESET;
      rw_reg <= 1'b0;
      after_addr_reg <= 1'b0;
      tx_reg <= BYTE_RESET;
      sel <= '{reg_code: SEL_REG_RESET, port: SEL_PORT_RESET};
    end else if (clk_en) begin
      state_reg <= state_next;
      if (start_ev || (scl_fall && (byte_done || state_reg == ST_ACK))) begin
        bit_cnt_reg <= BIT_CNT_RESET;
      end else if (scl_rise && state_reg != ST_ACK && state_reg != ST_MACK) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[6:0], sda_s};
      end
      if (state_reg == ST_ADDR && scl_fall && byte_done) begin
        rw_reg <= shift_reg[0];
        after_addr_reg <= 1'b1;
      end else if (state_reg == ST_SEL && scl_fall && byte_done) begin
        after_addr_reg <= 1'b0;
        sel.reg_code <= rx_code;
        sel.port <= rx_port;
      end
      if (state_reg == ST_ACK && scl_fall && after_addr_reg && rw_reg) begin
        tx_reg <= rd_byte;
      end else if (state_reg == ST_RDATA && scl_fall) begin
        tx_reg <= {tx_reg[6:0], 1'b1};
      end
    end
  end

  // Output drive: low enable drives zero on the open output
  wire tx_next_msb = (state_reg == ST_ACK) ? rd_byte[7] :
                     (scl_fall ? tx_reg[6] : tx_reg[7]);
  wire drive_low = (state_next == ST_ACK) ||
                   (state_next == ST_RDATA && !tx_next_msb);
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sda_out_oen <= 1'b1;
      read_active <= 1'b0;
    end else if (clk_en) begin
      sda_out_oen <= !drive_low;
      read_active <= (state_next == ST_RDATA);
    end
  end

  // Checks
  sequence s_addr_ack;
    (state_reg == ST_ADDR) && scl_fall && byte_done && addr_match && !start_ev && !stop_ev;
  endsequence

  chk_addr_ack_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en and s_addr_ack) |=> !sda_out_oen)
    else $error("address acknowledge not driven");
  chk_mismatch_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && state_reg == ST_ADDR && scl_fall && byte_done && !addr_match
    && !start_ev |=> state_reg == ST_IDLE)
    else $error("mismatched address not ignored");
  chk_sel_latch: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && state_reg == ST_SEL && scl_fall && byte_done
    |=> sel.reg_code == $past(rx_code) && sel.port == $past(rx_port))
    else $error("selection not latched");
  chk_sel_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg != ST_SEL |=> $stable(sel))
    else $error("selection changed outside select byte");
  chk_data_msb: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && state_reg == ST_ACK && scl_fall && after_addr_reg && rw_reg && !stop_ev
    && !start_ev |=> sda_out_oen == rd_byte[7] ##0 tx_reg == rd_byte)
    else $error("first data bit wrong");
  chk_release_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg == ST_IDLE && !start_ev |=> sda_out_oen)
    else $error("output driven while idle");
  chk_stop_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && stop_ev |=> state_reg == ST_IDLE ##1 sda_out_oen || state_reg != ST_IDLE)
    else $error("stop not honoured");
  chk_mack_release: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg == ST_MACK |-> sda_out_oen)
    else $error("device drove during host acknowledge");

endmodule

// *** dv/srp_host_model.sv ***
// Behavioural bus master for the serial register port slave.
// Assumes the slave's open output line has a pull-up when released.
`timescale 1ns/1ps

module srp_host_model (
  // Host driven pins
  output logic scl,
  output logic sda,
  // Slave open output enable
  input wire logic sda_out_oen
);
  // Return line: low while driven, pulled up when released
  wire line = sda_out_oen;

  // Bus idle at time zero
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // One 125 ns clock pulse: data set while low, line sampled at the rising edge
  task automatic bit_io(input logic b, output logic r);
    #20 sda = b;
    #40 scl = 1'b1;
    r = line;
    #65 scl = 1'b0;
  endtask

  // Start, also the restart after a stop
  task automatic start();
    #60 sda = 1'b0;
    #60 scl = 1'b0;
  endtask

  // Stop closes every transfer
  task automatic stop();
    #40 sda = 1'b0;
    #80 scl = 1'b1;
    #60 sda = 1'b1;
    #60;
  endtask

  // Byte out MSB first, returns the acknowledge level
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, ack);
  endtask

  // Byte in MSB first, host answers with the line held high
  task automatic read_byte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(1'b1, r);
  endtask
endmodule

// *** dv/serial_reg_port_select_read_tb.sv ***
// Self-checking bench for the serial register port slave.
// Assumes the host model in its own file and the slave's package.
`timescale 1ns/1ps

module serial_reg_port_select_read_tb;
  import srp_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] pins = 5'h15;
  logic [7:0] vals [16];
  logic scl, sda, oen, ract;
  logic clk_en = 1'b1;
  srp_sel_t sel;
  int bad_count = 0;
  int tests_run = 0;

  // System clock
  always #5 sys_clk = ~sys_clk;

  // Host and slave
  srp_host_model srp_host_model_inst (.scl(scl), .sda(sda), .sda_out_oen(oen));
  srp_slave srp_slave_inst (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .scl_in(scl), .sda_in(sda), .sda_out_oen(oen), .address_select_pins(pins),
    .common_read_val(vals[0]), .common_ctrl_val(vals[1]), .port_ctrl1_val(vals[2]),
    .port_ctrl2_val(vals[3]), .port_stat1_val(vals[4]), .port_stat2_val(vals[5]),
    .res_val({vals[7], vals[6]}), .volt_val({vals[9], vals[8]}),
    .curr_val({vals[11], vals[10]}), .temp_val({vals[13], vals[12]}),
    .test_val(vals[15]), .sel(sel), .read_active(ract));

  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Outputs after reset
  task automatic test_reset();
    check({2'h0, sel}, 8'h00, "sel at reset");
    check({7'h0, oen}, 8'h01, "oen at reset");
  endtask

  // Select write with spare bits set, then restart and read back
  task automatic test_code(input logic [3:0] c, input logic [1:0] p);
    logic ack;
    logic [7:0] d;
    srp_host_model_inst.start();
    srp_host_model_inst.send_byte({2'b11, pins, 1'b0}, ack);
    check({7'h0, ack}, 8'h00, "write address ack");
    srp_host_model_inst.send_byte({1'b1, c, 1'b1, p}, ack);
    check({7'h0, ack}, 8'h00, "select ack");
    check({2'h0, sel}, {2'h0, c, p}, "select latch");
    srp_host_model_inst.stop();
    srp_host_model_inst.start();
    srp_host_model_inst.send_byte({2'b00, pins, 1'b1}, ack);
    check({7'h0, ack}, 8'h00, "read address ack");
    fork
      srp_host_model_inst.read_byte(d);
      #60 check({7'h0, ract}, 8'h01, "read active in byte");
    join
    check(d, (c == REG_UNUSED) ? UNUSED_READ : vals[c], "read data");
    srp_host_model_inst.stop();
    check({7'h0, ract}, 8'h00, "read active after stop");
  endtask

  // Clock enable low: a full select write is neither acknowledged nor latched
  task automatic test_freeze();
    logic ack;
    srp_sel_t keep;
    keep = sel;
    @(negedge sys_clk) clk_en = 1'b0;
    #2.5;
    srp_host_model_inst.start();
    srp_host_model_inst.send_byte({2'b00, pins, 1'b0}, ack);
    check({7'h0, ack}, 8'h01, "frozen address ack");
    srp_host_model_inst.send_byte({1'b0, ~keep.reg_code, 1'b0, ~keep.port}, ack);
    check({7'h0, ack}, 8'h01, "frozen select ack");
    srp_host_model_inst.stop();
    @(negedge sys_clk) clk_en = 1'b1;
    #2.5;
    check({2'h0, sel}, {2'h0, keep}, "frozen select");
  endtask

  // Foreign address gets no acknowledge
  task automatic test_wrong_addr();
    logic ack;
    srp_host_model_inst.start();
    srp_host_model_inst.send_byte({2'b00, pins ^ 5'h01, 1'b1}, ack);
    check({7'h0, ack}, 8'h01, "foreign address ack");
    srp_host_model_inst.stop();
  endtask

  // Main sequence; register codes loop covers every code and port
  initial begin
    for (int i = 0; i < 16; i++) begin
      vals[i] = {i[3:0], ~i[3:0]};
    end
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    test_reset();
    // Keep host pin changes clear of sys_clk edges
    #2.5;
    for (int i = 0; i < 16; i++) begin
      test_code(i[3:0], i[1:0] ^ 2'h2);
    end
    test_freeze();
    test_wrong_addr();
    test_done();
  end

  // Watchdog
  initial begin
    #400000;
    bad_count++;
    test_done();
  end
endmodule
